// >>> verilog/serial_baud_rate_generator.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module serial_baud_rate_generator
    import rate_gen_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_pin,
    output logic             bit_tick,
    output logic             rx_level,
    output logic             clock_master
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic reg_sel_e decode(input logic [11:0] addr);
        unique case (addr)
            OFS_TX_CTRL:   decode = SEL_TX_CTRL;
            OFS_RX_CTRL:   decode = SEL_RX_CTRL;
            OFS_RATE_CTRL: decode = SEL_RATE_CTRL;
            OFS_DIV_HIGH:  decode = SEL_DIV_HIGH;
            OFS_DIV_LOW:   decode = SEL_DIV_LOW;
            default:       decode = SEL_NONE;
        endcase
    endfunction

    // prescale length per mode
    function automatic logic [3:0] pre_last(input rate_cfg_s c);
        if (c.sync_mode)
            pre_last = PRE_LAST_DIV4;                     // [R4] [R7]
        else if (c.wide && c.high_speed)
            pre_last = PRE_LAST_DIV4;                     // [R14]
        else if (c.wide || c.high_speed)
            pre_last = PRE_LAST_DIV16;                    // [R3] [R6]
        else
            pre_last = PRE_LAST_DIV64;                    // [R5]
    endfunction

    function automatic logic [15:0] div_value(input logic       wide,
                                              input logic [7:0] hi,
                                              input logic [7:0] lo);
        div_value = wide ? {hi, lo} : {8'h00, lo};        // [R8] [R15] [R1]
    endfunction

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0]  tx_ctrl_r;
    logic [7:0]  rx_ctrl_r;
    logic [7:0]  rate_ctrl_r;
    logic [7:0]  div_high_r;
    logic [7:0]  div_low_r;
    reg_sel_e    sel;
    logic        wr_en;
    logic        div_wr;
    rate_cfg_s   cfg;
    logic [15:0] n_val;

    assign sel    = decode(paddr);
    assign wr_en  = psel && penable && pready && pwrite;
    assign div_wr = wr_en && (sel == SEL_DIV_HIGH || sel == SEL_DIV_LOW);
    // one driver for the whole struct
    assign cfg    = '{
        wide:         rate_ctrl_r[BIT_WIDE_DIVIDER],
        high_speed:   tx_ctrl_r[BIT_HIGH_SPEED],
        sync_mode:    tx_ctrl_r[BIT_SYNC_MODE],
        clock_source: tx_ctrl_r[BIT_CLOCK_SOURCE]
    };
    assign n_val = div_value(cfg.wide, div_high_r, div_low_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_ctrl_r   <= RST_BYTE;
            rx_ctrl_r   <= RST_BYTE;
            rate_ctrl_r <= RST_BYTE;
            div_high_r  <= RST_BYTE;
            div_low_r   <= RST_BYTE;
        end
        else if (wr_en)
        begin
            unique case (sel)
                SEL_TX_CTRL:   tx_ctrl_r   <= pwdata[7:0] & TX_CTRL_WMASK;
                SEL_RX_CTRL:   rx_ctrl_r   <= pwdata[7:0] & RX_CTRL_WMASK;
                SEL_RATE_CTRL: rate_ctrl_r <= pwdata[7:0] & RATE_CTRL_WMASK;
                SEL_DIV_HIGH:  div_high_r  <= pwdata[7:0];
                SEL_DIV_LOW:   div_low_r   <= pwdata[7:0];
                SEL_NONE:      ;
            endcase
        end
    end

    // ----------------------------------------
    // apb answer: no wait states, error on unmapped
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (sel == SEL_NONE);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (sel)
                    SEL_TX_CTRL:   prdata[7:0] <= tx_ctrl_r | TX_CTRL_RO;
                    SEL_RX_CTRL:   prdata[7:0] <= rx_ctrl_r;
                    SEL_RATE_CTRL: prdata[7:0] <= rate_ctrl_r | RATE_CTRL_RO;
                    SEL_DIV_HIGH:  prdata[7:0] <= div_high_r;
                    SEL_DIV_LOW:   prdata[7:0] <= div_low_r;
                    SEL_NONE:      prdata[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------
    // rate timer
    // ----------------------------------------
    // prescaler, timer and phase all clear on a divisor write so the new
    // rate starts at once; mode changes apply from the next cycle without clearing them
    logic [3:0]  pre_r;
    logic [15:0] timer_r;
    logic [1:0]  phase_r;
    logic        pre_tick;
    logic        overflow;
    logic        master;

    assign pre_tick = (pre_r >= pre_last(cfg));
    assign overflow = pre_tick && (timer_r >= n_val);
    assign master   = !cfg.sync_mode || cfg.clock_source;       // [R16]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_r <= 4'h0;
        else if (div_wr)
            pre_r <= 4'h0;                                      // [R10]
        else if (pre_tick)
            pre_r <= 4'h0;
        else
            pre_r <= pre_r + 4'h1;                              // [R11]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_r <= 16'h0000;
        else if (div_wr)
            timer_r <= 16'h0000;                                // [R10]
        else if (overflow)
            timer_r <= 16'h0000;                                // [R2]
        else if (pre_tick)
            timer_r <= timer_r + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_r <= 2'h0;
        else if (div_wr)
            phase_r <= 2'h0;
        else if (overflow)
            phase_r <= phase_r + 2'h1;
    end

    // slave in clocked mode gives no bit tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_tick     <= 1'b0;
            clock_master <= 1'b0;
        end
        else
        begin
            bit_tick     <= overflow && (phase_r == PHASE_LAST) && master && !div_wr; // [R9]
            clock_master <= cfg.sync_mode && cfg.clock_source;   // [R16]
        end
    end

    // ----------------------------------------
    // receive pin majority detect
    // ----------------------------------------
    logic [2:0] rx_sync_r;
    logic       rx_clean_r;
    logic [1:0] samp_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_sync_r <= 3'b111;
        else
            rx_sync_r <= {rx_sync_r[1:0], rx_pin};
    end

    // idle line is high, so every stage resets high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_clean_r <= 1'b1;
        else if (rx_sync_r[1] == rx_sync_r[2])
            rx_clean_r <= rx_sync_r[2];
    end

    // three samples a quarter bit apart, at the half, three-quarter and end points of each bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            samp_r   <= 2'b11;
            rx_level <= 1'b1;
        end
        else if (overflow && !div_wr)
        begin
            if (phase_r == PHASE_LAST)
                rx_level <= (samp_r[0] & samp_r[1]) | (samp_r[0] & rx_clean_r)
                          | (samp_r[1] & rx_clean_r);          // [R13]
            else
                samp_r <= {samp_r[0], rx_clean_r};
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // gap between ticks, valid only after an unbroken run of one setting
    logic [23:0] gap_r;
    logic        gap_ok_r;
    logic [23:0] expect_gap;
    logic        wr_any;

    assign wr_any     = wr_en && sel != SEL_NONE;
    assign expect_gap = 24'(PHASES) * 24'({20'h0_0000, pre_last(cfg)} + 24'h1)
                      * 24'({8'h00, n_val} + 24'h1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_r    <= 24'h00_0000;
            gap_ok_r <= 1'b0;
        end
        else
        begin
            gap_r    <= bit_tick ? 24'h00_0001 : gap_r + 24'h00_0001;
            gap_ok_r <= wr_any ? 1'b0 : (bit_tick ? 1'b1 : gap_ok_r);
        end
    end

    sequence s_tick_valid;
        bit_tick && gap_ok_r && !wr_any;
    endsequence

    AST_RATE_DIV64: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        s_tick_valid and (!cfg.sync_mode && !cfg.wide && !cfg.high_speed)
        |-> gap_r == 24'd64 * 24'({8'h00, n_val} + 24'h1))
        else $error("low speed 8-bit async period wrong");

    AST_RATE_DIV16: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        s_tick_valid and (!cfg.sync_mode && (cfg.wide != cfg.high_speed))
        |-> gap_r == 24'd16 * 24'({8'h00, n_val} + 24'h1))
        else $error("divide by 16 async period wrong");

    AST_RATE_SYNC: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        s_tick_valid and (cfg.sync_mode)
        |-> gap_r == 24'd4 * 24'({8'h00, n_val} + 24'h1))
        else $error("clocked master period wrong");

    AST_RATE_WIDE_FAST: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        s_tick_valid and (cfg.wide && cfg.high_speed)
        |-> gap_r == 24'd4 * 24'({8'h00, n_val} + 24'h1))
        else $error("16-bit fast period wrong");

    AST_GAP_FORMULA: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        s_tick_valid |-> gap_r == expect_gap)
        else $error("tick gap does not match mode");

    AST_DIV_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        div_wr |=> timer_r == 16'h0000 && pre_r == 4'h0 && phase_r == 2'h0 && !bit_tick)
        else $error("divisor write did not clear timer");

    AST_LOW_BYTE_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        !cfg.wide && $stable(cfg) |-> timer_r[15:8] == 8'h00)
        else $error("high byte used in 8-bit mode");

    AST_SLAVE_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        (cfg.sync_mode && !cfg.clock_source) [*2] |-> !bit_tick)
        else $error("tick in clocked slave mode");

    sequence s_steady_low;
        (rx_clean_r == 1'b0) [*8];
    endsequence

    AST_MAJORITY: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        s_steady_low ##0 (pre_last(cfg) == PRE_LAST_DIV4 && n_val == 16'h0000)
        |-> ##1 !rx_level)
        else $error("majority missed a steady low");

    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb ready not one cycle after setup");

    AST_TICK_SINGLE: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        bit_tick |=> !bit_tick)
        else $error("bit tick longer than one cycle");

    sequence s_master_cfg;
        cfg.sync_mode && cfg.clock_source;
    endsequence

    AST_MASTER_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        s_master_cfg |=> clock_master)
        else $error("clock master flag missing");

    AST_SLAVE_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        !(cfg.sync_mode && cfg.clock_source) |=> !clock_master)
        else $error("clock master flag outside clocked master");

    // level may only move at the end of a bit, never between votes
    AST_RX_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        !(overflow && !div_wr && phase_r == PHASE_LAST) |=> $stable(rx_level))
        else $error("receive level moved between votes");

    // a pin change counts only once two stages agree
    AST_RX_FILTER: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        rx_sync_r[1] != rx_sync_r[2] |=> $stable(rx_clean_r))
        else $error("receive filter passed a disagreeing pin");

endmodule

// >>> shared/rate_gen_pkg.sv
// What this block does
// [R1] 8-bit timer at reset, 16-bit when wide set
// [R2] free-running timer period set by divisor pair
// [R3] async rate uses high-speed and wide-divider bits
// [R4] clocked mode ignores the high-speed bit
// [R5] async, 8-bit, low speed: clock/(64(n+1))
// [R6] 8-bit fast or 16-bit slow: clock/(16(n+1))
// [R7] clocked 8-bit: clock/(4(n+1))
// [R8] n is high byte over low byte
// [R9] formulas apply only as clocked master
// [R10] divisor write clears the rate timer
// [R11] timer counts on the system clock
// [R12] software rewrites divisor after clock change
// [R13] receive pin majority of three samples
// [R14] 16-bit fast async or clocked: clock/(4(n+1))
// [R15] 8-bit mode ignores the high divisor byte
// [R16] clock source set means master, clear slave
package rate_gen_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] OFS_TX_CTRL   = 12'h000;
    localparam logic [11:0] OFS_RX_CTRL   = 12'h004;
    localparam logic [11:0] OFS_RATE_CTRL = 12'h008;
    localparam logic [11:0] OFS_DIV_HIGH  = 12'h00C;
    localparam logic [11:0] OFS_DIV_LOW   = 12'h010;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_CLOCK_SOURCE = 7;
    localparam int BIT_SYNC_MODE    = 4;
    localparam int BIT_HIGH_SPEED   = 2;
    localparam int BIT_WIDE_DIVIDER = 3;

    // ----------------------------------------
    // reset values and access masks
    // ----------------------------------------
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] TX_CTRL_WMASK   = 8'hFD;
    localparam logic [7:0] TX_CTRL_RO      = 8'h02;
    localparam logic [7:0] RX_CTRL_WMASK   = 8'hF8;
    localparam logic [7:0] RATE_CTRL_WMASK = 8'hBB;
    localparam logic [7:0] RATE_CTRL_RO    = 8'h40;

    // ----------------------------------------
    // timing: prescale last counts, divide = 4*(last+1)
    // ----------------------------------------
    localparam logic [3:0] PRE_LAST_DIV64 = 4'hF;
    localparam logic [3:0] PRE_LAST_DIV16 = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV4  = 4'h0;
    localparam logic [1:0] PHASE_LAST     = 2'h3;
    localparam int         PHASES         = 4;

    typedef enum logic [2:0] {
        SEL_TX_CTRL,
        SEL_RX_CTRL,
        SEL_RATE_CTRL,
        SEL_DIV_HIGH,
        SEL_DIV_LOW,
        SEL_NONE
    } reg_sel_e;

    typedef struct packed {
        logic wide;
        logic high_speed;
        logic sync_mode;
        logic clock_source;
    } rate_cfg_s;

endpackage

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rate_gen_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [11:0] OFS_ALL [5] = '{OFS_TX_CTRL, OFS_RX_CTRL, OFS_RATE_CTRL,
                                            OFS_DIV_HIGH, OFS_DIV_LOW};
    localparam logic [7:0]  WM_ALL  [5] = '{TX_CTRL_WMASK, RX_CTRL_WMASK, RATE_CTRL_WMASK,
                                            8'hFF, 8'hFF};
    localparam logic [7:0]  RO_ALL  [5] = '{TX_CTRL_RO, 8'h00, RATE_CTRL_RO, 8'h00, 8'h00};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_pin;
    logic        bit_tick;
    logic        rx_level;
    logic        clock_master;
    logic [32:0] exp_q [$];
    logic [32:0] note;
    logic [7:0]  d;
    logic [7:0]  lo;
    int          err_count;
    int          n_compared;
    int          c;
    int          p;
    int          n;

    serial_baud_rate_generator DUT (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .rx_pin       (rx_pin),
        .bit_tick     (bit_tick),
        .rx_level     (rx_level),
        .clock_master (clock_master)
    );

    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    task results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // request held until pready seen; idle edge after keeps drives apart
    task apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
        int k;
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'h1 && k < 20);
        check({31'h0, pready}, 32'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        exp_q.push_back({err, exp});
        apb(1'h0, a, 8'h00);
    endtask

    task cfg(input logic sy, input logic wi, input logic hs, input logic cs,
             input logic [7:0] hi, input logic [7:0] lw);
        apb(1'h1, OFS_TX_CTRL, {cs, 2'h0, sy, 1'h0, hs, 2'h0});
        apb(1'h1, OFS_RATE_CTRL, {4'h0, wi, 3'h0});
        apb(1'h1, OFS_DIV_HIGH, hi);
        apb(1'h1, OFS_DIV_LOW, lw);
    endtask

    task wait_tick(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge pclk);
            cyc++;
        end
        while (bit_tick !== 1'h1 && cyc < 20000);
    endtask

    // ----------------------------------------
    // read result monitor
    // ----------------------------------------
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            check(prdata, note[31:0]);
            check({31'h0, pslverr}, {31'h0, note[32]});
        end
    end

    initial
    begin
        // tests take about 30k cycles, the widest slow mode most of it
        repeat (50000) @(posedge pclk);
        err_count++;
        results();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        rx_pin = 1'h1;
        err_count = 0;
        n_compared = 0;
        c = $urandom(44155);
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        check({31'h0, bit_tick}, 32'h0);
        check({31'h0, clock_master}, 32'h0);
        check({31'h0, rx_level}, 32'h1);
        for (int i = 0; i < 5; i++)
            rd(OFS_ALL[i], {24'h000000, RO_ALL[i]}, 1'h0);
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($urandom);
            apb(1'h1, OFS_ALL[i], d);
            rd(OFS_ALL[i], {24'h000000, (d & WM_ALL[i]) | RO_ALL[i]}, 1'h0);
        end
        apb(1'h1, 12'h014, 8'hFF);
        rd(12'h014, 32'h00000000, 1'h1);
        // every mode; high byte 1 must be ignored unless wide
        for (int m = 0; m < 8; m++)
        begin
            lo = 8'($urandom % 8);
            cfg(m[2], m[1], m[0], 1'h1, 8'h01, lo);
            n = m[1] ? 256 + lo : lo;
            p = (m[2] || (m[1] && m[0])) ? 4 : ((m[1] ^ m[0]) ? 16 : 64);
            p = p * (n + 1);
            check({31'h0, clock_master}, {31'h0, m[2]});
            wait_tick(c);
            check({31'h0, (c + 1 >= p) && (c + 1 <= p + 2)}, 32'h1);
            wait_tick(c);
            check(32'(c), 32'(p));
            repeat (p / 2) @(posedge pclk);
            apb(1'h1, OFS_DIV_LOW, lo);
            wait_tick(c);
            check({31'h0, (c + 1 >= p) && (c + 1 <= p + 2)}, 32'h1);
        end
        cfg(1'h1, 1'h0, 1'h1, 1'h0, 8'h00, 8'h00);
        check({31'h0, clock_master}, 32'h0);
        c = 0;
        repeat (200)
        begin
            @(posedge pclk);
            c = c + bit_tick;
        end
        check(32'(c), 32'h0);
        // fastest rate: a sample in three cycles of every 4, a vote every 4, steady levels must pass
        cfg(1'h1, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00);
        rx_pin <= 1'h0;
        repeat (24) @(posedge pclk);
        check({31'h0, rx_level}, 32'h0);
        rx_pin <= 1'h1;
        repeat (24) @(posedge pclk);
        check({31'h0, rx_level}, 32'h1);
        // samples 4 cycles apart: a 2-cycle low meets one sample at most
        apb(1'h1, OFS_DIV_LOW, 8'h03);
        repeat (8)
        begin
            rx_pin <= 1'h0;
            repeat (2) @(posedge pclk);
            rx_pin <= 1'h1;
            repeat (18)
            begin
                @(posedge pclk);
                check({31'h0, rx_level}, 32'h1);
            end
        end
        rx_pin <= 1'h0;
        repeat (40) @(posedge pclk);
        check({31'h0, rx_level}, 32'h0);
        rx_pin <= 1'h1;
        results();
    end
endmodule
